// ### rtl/dsfct_serial.sv
// What this block does
// - six balance timers set each balance output on time, 1 to 30 minutes; zero means no limit.
// - balance timer minutes in bits 7..3; bits 2..0 reserved, write zero.
// - all balance timers hold zero after reset.
// - sleep delay timer, 0 to 31 minutes, requests power-down; resets to zero.
// - sleep delay minutes in bits 7..3; bits 2..0 reserved, write zero.
// - read select picks next readback register; zero selects conversion results.
// - read select address in bits 7..2; bits 1..0 reserved, write zero.
// - serial input sampled and output launched on falling serial clock.
// - chip select frames transfers and starts the conversion sequence.
// - write frame: device, register, data, all-parts bit, three zeros.
// - conversion frame: device, channel, 12-bit result, 2-bit check.
// - register frame: device, register, 8-bit value, two zeros, check.
// - conversion readout spans N back-to-back 24-bit frames.
// - chip select held low across frames or pulsed per frame both work.
// - device address sent LSB first; all other fields MSB first.
// - check bits are remainder of bits 17..2 divided by x^2+1.
// - two stages and one xor, cleared, stepped over 16 input bits.
// - conversion check covers channel and result only, not device address.
// - all-parts bit addresses the write to every device in chain.
// - nonzero device address is decremented and forwarded, all-parts writes forwarded unchanged; zero acts.
// - readout frames passed toward host get device address incremented.

module dsfct_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = dsfct_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointers wrap by overflow, so depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  // occupancy after this cycle's push and pop
  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = count_q + 1'b1;
    end
    else if (pop && !push)
    begin
      count_d = count_q - 1'b1;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and registered full / empty flags
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      count_q   <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q   <= count_d;
      in_ready  <= (count_d != (PW + 1)'(DEPTH));
      out_valid <= (count_d != '0);
    end
  end
endmodule // dsfct_fifo

module dsfct_serial #(
  parameter logic [31:0] MINUTE_CYCLES = 32'(dsfct_pkg::MINUTE_CYCLES),
  parameter int          FIFO_DEPTH    = dsfct_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       serial_clk,
  input  wire logic                       chip_select_n,
  input  wire logic                       serial_in_line,
  output logic                            serial_out_line,
  input  wire logic [5:0]                 balance_request,
  output logic [5:0]                      balance_output,
  output logic                            sleep_request,
  output logic                            convert_start,
  input  wire logic                       conv_valid,
  output logic                            conv_ready,
  input  wire dsfct_pkg::dsfct_conv_type  conv_word,
  output dsfct_pkg::dsfct_write_type      up_frame,
  output logic                            up_valid,
  input  wire dsfct_pkg::dsfct_read_type  chain_rd_frame,
  input  wire logic                       chain_rd_valid,
  output dsfct_pkg::dsfct_read_type       down_frame,
  output logic                            down_valid
);
  if (MINUTE_CYCLES < 32'h0000_0002)
  begin : g_bad_minute
    $error("minute count must be at least 2 cycles");
  end

  // reverse a 6-bit device address for LSB-first transfer
  function automatic logic [5:0] flip6(input logic [5:0] v);
    logic [5:0] r;
    r = '0;
    for (int k = 0; k < 6; k++)
    begin
      r[k] = v[5 - k];
    end
    return r;
  endfunction

  // check bits over 16 bits, fed from bit 15 (frame bit 17) downwards
  function automatic logic [1:0] check_bits(input logic [15:0] d);
    logic s1;
    logic s2;
    logic x;
    s1 = 1'b0;
    s2 = 1'b0;
    x  = 1'b0;
    for (int k = 15; k >= 0; k--)
    begin
      s2 = s1;
      s1 = x;
      x  = d[k] ^ s2;
    end
    return {s1, x};
  endfunction

  logic [2:0]  sclk_sync_q;
  logic [1:0]  cs_sync_q;
  logic        cs_prev_q;
  logic [1:0]  sdi_sync_q;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_active;
  logic        sdi_s;

  // pins cross two flops before anything reads them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_sync_q <= 3'h7;
      cs_sync_q   <= 2'h3;
      cs_prev_q   <= 1'b1;
      sdi_sync_q  <= 2'h0;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[1:0], serial_clk};
      cs_sync_q   <= {cs_sync_q[0], chip_select_n};
      cs_prev_q   <= cs_sync_q[1];
      sdi_sync_q  <= {sdi_sync_q[0], serial_in_line};
    end
  end

  // edges judged on synchronised copies only
  assign sclk_fall = sclk_sync_q[2] && !sclk_sync_q[1];
  assign cs_fall   = cs_prev_q && !cs_sync_q[1];
  assign cs_active = !cs_sync_q[1];
  assign sdi_s     = sdi_sync_q[1];

  logic [22:0]                rx_q;
  logic [4:0]                 bit_cnt_q;
  logic                       frame_end;
  logic [23:0]                rx_word;
  dsfct_pkg::dsfct_write_type wr;
  logic [5:0]                 wr_dev;
  logic                       wr_hit;

  assign frame_end = cs_active && sclk_fall && (bit_cnt_q == dsfct_pkg::FRAME_LAST_BIT);
  assign rx_word   = {rx_q, sdi_s};
  assign wr        = dsfct_pkg::dsfct_write_type'(rx_word);
  assign wr_dev    = flip6(wr.dev_addr);
  assign wr_hit    = frame_end && ((wr_dev == dsfct_pkg::OWN_ADDRESS) || wr.all_parts);

  // count wraps, so held or pulsed select both frame
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_q      <= '0;
      bit_cnt_q <= '0;
    end
    else if (!cs_active)
    begin
      bit_cnt_q <= '0;
    end
    else if (sclk_fall)
    begin
      rx_q      <= rx_word[22:0];
      bit_cnt_q <= frame_end ? 5'h00 : bit_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      up_frame <= '0;
      up_valid <= 1'b0;
    end
    else
    begin
      // all-parts writes go on up unchanged
      up_valid <= frame_end && ((wr_dev != dsfct_pkg::OWN_ADDRESS) || wr.all_parts);
      if (frame_end)
      begin
        up_frame          <= wr;
        up_frame.dev_addr <= wr.all_parts ? wr.dev_addr : flip6(wr_dev - 6'h01);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      down_frame <= '0;
      down_valid <= 1'b0;
    end
    else
    begin
      down_valid <= chain_rd_valid;
      if (chain_rd_valid)
      begin
        down_frame          <= chain_rd_frame;
        down_frame.dev_addr <= chain_rd_frame.dev_addr + 6'h01;
      end
    end
  end

  logic [4:0] bal_min_q [dsfct_pkg::BALANCE_COUNT];
  logic [4:0] sleep_min_q;
  logic [5:0] select_q;
  logic [4:0] wr_minutes;
  logic       sleep_load;

  assign wr_minutes = wr.data[dsfct_pkg::MINUTE_FIELD_MSB:dsfct_pkg::MINUTE_FIELD_LSB];
  assign sleep_load = wr_hit && (wr.reg_addr == dsfct_pkg::OFS_SLEEP_DELAY);

  // timers and select reset to zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < dsfct_pkg::BALANCE_COUNT; i++)
      begin
        bal_min_q[i] <= dsfct_pkg::BALANCE_RESET;
      end
      sleep_min_q <= dsfct_pkg::SLEEP_RESET;
      select_q    <= dsfct_pkg::SELECT_RESET;
    end
    else if (wr_hit)
    begin
      for (int i = 0; i < dsfct_pkg::BALANCE_COUNT; i++)
      begin
        if (wr.reg_addr == dsfct_pkg::OFS_BALANCE_FIRST + 6'(i))
        begin
          bal_min_q[i] <= (wr_minutes > dsfct_pkg::BALANCE_MAX_MIN) ?
                          dsfct_pkg::BALANCE_MAX_MIN : wr_minutes;
        end
      end
      if (sleep_load)
      begin
        sleep_min_q <= wr_minutes;
      end
      if (wr.reg_addr == dsfct_pkg::OFS_READ_SELECT)
      begin
        select_q <= wr.data[dsfct_pkg::SELECT_FIELD_MSB:dsfct_pkg::SELECT_FIELD_LSB];
      end
    end
  end

  logic [31:0] tick_cnt_q;
  logic        minute_tick;

  // free-running minute prescaler shared by all timers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= minute_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end
  end
  assign minute_tick = (tick_cnt_q == MINUTE_CYCLES - 32'h0000_0001);

  for (genvar g = 0; g < dsfct_pkg::BALANCE_COUNT; g++)
  begin : g_balance
    logic [4:0] left_q;
    logic       expired_q;
    logic       req_prev_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        left_q            <= '0;
        expired_q         <= 1'b0;
        req_prev_q        <= 1'b0;
        balance_output[g] <= 1'b0;
      end
      else
      begin
        req_prev_q <= balance_request[g];
        if (balance_request[g] && !req_prev_q)
        begin
          left_q    <= bal_min_q[g];
          expired_q <= 1'b0;
        end
        else if (minute_tick && balance_request[g] && left_q != 5'h00)
        begin
          left_q    <= left_q - 5'h01;
          expired_q <= (left_q == 5'h01);
        end
        balance_output[g] <= balance_request[g] && !(expired_q && bal_min_q[g] != 5'h00);
      end
    end
  end

  logic [4:0] sleep_left_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleep_left_q  <= dsfct_pkg::SLEEP_RESET;
      sleep_request <= 1'b0;
    end
    else if (sleep_load)
    begin
      // restart on every write; zero leaves it idle
      sleep_left_q  <= wr_minutes;
      sleep_request <= 1'b0;
    end
    else if (minute_tick && sleep_left_q != 5'h00)
    begin
      sleep_left_q <= sleep_left_q - 5'h01;
      if (sleep_left_q == 5'h01)
      begin
        sleep_request <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      convert_start <= 1'b0;
    end
    else
    begin
      convert_start <= cs_fall;
    end
  end

  dsfct_pkg::dsfct_conv_type fifo_word;
  logic                      fifo_valid;
  logic                      fifo_pop;
  logic                      tx_load;
  logic                      conv_mode;
  logic [7:0]                reg_value;
  dsfct_pkg::dsfct_read_type tx_frame;
  logic [23:0]               tx_bits;
  logic [23:0]               tx_q;
  logic                      tx_held_q;

  // conversion results wait here until the host clocks them out
  dsfct_fifo #(
    .WIDTH ($bits(dsfct_pkg::dsfct_conv_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (conv_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word)
  );

  assign conv_mode = (select_q == 6'h00);
  // each frame boundary loads the next result
  assign tx_load   = frame_end || (cs_fall && !(tx_held_q && conv_mode));
  assign fifo_pop  = tx_load && conv_mode && fifo_valid;

  // popped but not yet shifted; a select pulse must not pop a second word
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_held_q <= 1'b0;
    end
    else if (frame_end)
    begin
      tx_held_q <= fifo_pop;
    end
    else if (cs_active && sclk_fall)
    begin
      tx_held_q <= 1'b0;
    end
  end

  // register value for readback; reserved bits read zero
  always_comb
  begin
    reg_value = 8'h00;
    for (int i = 0; i < dsfct_pkg::BALANCE_COUNT; i++)
    begin
      if (select_q == dsfct_pkg::OFS_BALANCE_FIRST + 6'(i))
      begin
        reg_value = {bal_min_q[i], 3'h0};
      end
    end
    if (select_q == dsfct_pkg::OFS_SLEEP_DELAY)
    begin
      reg_value = {sleep_min_q, 3'h0};
    end
    if (select_q == dsfct_pkg::OFS_READ_SELECT)
    begin
      reg_value = {select_q, 2'h0};
    end
  end

  // outgoing frame; an empty queue sends channel 0, result 0
  always_comb
  begin
    tx_frame.dev_addr = dsfct_pkg::OWN_ADDRESS;
    tx_frame.payload  = fifo_valid ? 16'(fifo_word) : 16'h0000;
    if (!conv_mode)
    begin
      tx_frame.payload = {select_q, reg_value, 2'h0};
    end
    tx_frame.crc = check_bits(tx_frame.payload);
    tx_bits = {flip6(tx_frame.dev_addr), tx_frame.payload, tx_frame.crc};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_q            <= '0;
      serial_out_line <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_q            <= tx_bits;
      serial_out_line <= tx_bits[23];
    end
    else if (cs_active && sclk_fall)
    begin
      tx_q            <= {tx_q[22:0], 1'b0};
      serial_out_line <= tx_q[22];
    end
  end
endmodule // dsfct_serial

// ### rtl/dsfct_pkg.sv
package dsfct_pkg;

  // register offsets
  localparam logic [5:0] OFS_BALANCE_FIRST = 6'h15;
  localparam logic [5:0] OFS_BALANCE_LAST  = 6'h1A;
  localparam logic [5:0] OFS_SLEEP_DELAY   = 6'h1B;
  localparam logic [5:0] OFS_READ_SELECT   = 6'h1C;

  // field positions inside the 8-bit register value
  localparam int MINUTE_FIELD_LSB = 3;
  localparam int MINUTE_FIELD_MSB = 7;
  localparam int SELECT_FIELD_LSB = 2;
  localparam int SELECT_FIELD_MSB = 7;

  // reset values
  localparam logic [4:0] BALANCE_RESET = 5'h00;
  localparam logic [4:0] SLEEP_RESET   = 5'h00;
  localparam logic [5:0] SELECT_RESET  = 6'h00;

  // limits and counts
  localparam logic [4:0] BALANCE_MAX_MIN = 5'h1E;
  localparam int         BALANCE_COUNT   = 6;
  localparam int         FRAME_BITS      = 24;
  localparam logic [4:0] FRAME_LAST_BIT  = 5'h17;
  localparam logic [5:0] OWN_ADDRESS     = 6'h00;
  localparam int         FIFO_DEPTH      = 8;

  // timing: one minute at the 40 MHz system clock
  localparam longint CLK_HZ        = 40_000_000;
  localparam longint MINUTE_S      = 60;
  localparam longint MINUTE_CYCLES = CLK_HZ * MINUTE_S;

  // write frame as received, in frame field order
  typedef struct packed {
    logic [5:0] dev_addr;
    logic [5:0] reg_addr;
    logic [7:0] data;
    logic       all_parts;
    logic [2:0] pad;
  } dsfct_write_type;

  // readout frame, in frame field order
  typedef struct packed {
    logic [5:0]  dev_addr;
    logic [15:0] payload;
    logic [1:0]  crc;
  } dsfct_read_type;

  // one conversion result waiting for readout
  typedef struct packed {
    logic [3:0]  channel;
    logic [11:0] result;
  } dsfct_conv_type;

endpackage

// ### bench/dsfct_serial_sva.sv
module dsfct_serial_chk (
  input wire logic                      clk,
  input wire logic                      reset_n,
  input wire logic                      serial_clk,
  input wire logic                      chip_select_n,
  input wire logic                      serial_out_line,
  input wire logic [5:0]                balance_request,
  input wire logic [5:0]                balance_output,
  input wire logic                      sleep_request,
  input wire logic                      convert_start,
  input wire dsfct_pkg::dsfct_read_type chain_rd_frame,
  input wire logic                      chain_rd_valid,
  input wire dsfct_pkg::dsfct_read_type down_frame,
  input wire logic                      down_valid,
  input wire logic                      up_valid
);
  logic [3:0] since_edge_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // cycles since a pin edge; the pins pass a synchroniser, hence the slack
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      since_edge_q <= 4'h0;
    else if ($fell(serial_clk) || $fell(chip_select_n))
      since_edge_q <= 4'h0;
    else if (since_edge_q != 4'hF)
      since_edge_q <= since_edge_q + 4'h1;

  sequence s_relay_in;
    chain_rd_valid;
  endsequence

  sequence s_relay_out;
    down_valid && down_frame.dev_addr == $past(chain_rd_frame.dev_addr) + 6'h01;
  endsequence

  a_relay_adds_one: assert property (s_relay_in |=> s_relay_out)
    else $error("relayed frame address not incremented");
  a_relay_keeps_data: assert property (s_relay_in |=> down_frame.payload ==
    $past(chain_rd_frame.payload) && down_frame.crc == $past(chain_rd_frame.crc))
    else $error("relayed frame payload altered");
  a_relay_idle: assert property (!chain_rd_valid |=> !down_valid)
    else $error("relay output without input");
  a_select_starts: assert property ($fell(chip_select_n) |-> ##[1:5] convert_start)
    else $error("no conversion start after select");
  a_start_pulse: assert property (convert_start |=> !convert_start)
    else $error("conversion start longer than one cycle");
  a_forward_pulse: assert property (up_valid |=> !up_valid)
    else $error("forwarded write longer than one cycle");
  a_balance_gated: assert property (((balance_output &
    ~($past(balance_request) | $past(balance_request, 2))) == 6'h00))
    else $error("balance output on without request");
  a_sleep_holds: assert property (sleep_request && chip_select_n |=> sleep_request)
    else $error("sleep request dropped without a write");
  a_out_on_fall: assert property ($changed(serial_out_line) |-> since_edge_q <= 4'h8)
    else $error("serial output moved without a clock fall");
endmodule // dsfct_serial_chk

bind dsfct_serial dsfct_serial_chk chk_u (.clk, .reset_n, .serial_clk, .chip_select_n,
  .serial_out_line, .balance_request, .balance_output, .sleep_request, .convert_start,
  .chain_rd_frame, .chain_rd_valid, .down_frame, .down_valid, .up_valid);

// ### bench/dsfct_host_model.sv
module dsfct_host_model (
  output logic     serial_clk,
  output logic     chip_select_n,
  output logic     serial_in_line,
  input wire logic serial_out_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // link idles deselected with the clock parked high
  initial
  begin
    serial_clk     = 1'h1;
    chip_select_n  = 1'h1;
    serial_in_line = 1'h1;
  end

  // one 24-bit frame at 200 ns per bit; hold keeps select low for the next
  task automatic xfer(input logic [23:0] tx, input bit hold, output logic [23:0] rx);
    if (chip_select_n)
    begin
      chip_select_n = 1'h0;
      #200;
    end
    for (int k = 23; k >= 0; k--)
    begin
      serial_in_line = tx[k];
      #100;
      rx[k] = serial_out_line;
      serial_clk = 1'h0;
      #100;
      serial_clk = 1'h1;
    end
    #100;
    chip_select_n = !hold;
    serial_in_line = !tx[0]; // stale data never looks valid
    if (!hold)
      #300;
  endtask
endmodule // dsfct_host_model

// ### bench/dsfct_serial_bench.sv
module dsfct_serial_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                       clk;
  logic                       reset_n;
  logic                       serial_clk;
  logic                       chip_select_n;
  logic                       serial_in_line;
  logic                       serial_out_line;
  logic [5:0]                 balance_request;
  logic [5:0]                 balance_output;
  logic                       sleep_request;
  logic                       convert_start;
  logic                       conv_valid;
  logic                       conv_ready;
  dsfct_pkg::dsfct_conv_type  conv_word;
  dsfct_pkg::dsfct_write_type up_frame;
  logic                       up_valid;
  dsfct_pkg::dsfct_read_type  chain_rd_frame;
  logic                       chain_rd_valid;
  dsfct_pkg::dsfct_read_type  down_frame;
  logic                       down_valid;
  int                         fail_count;
  int                         total_checks;
  logic [31:0]                rng;
  logic [7:0]                 regs [0:63];
  logic [15:0]                convq [$];
  logic [23:0]                upq [$];
  logic [23:0]                rx;
  logic [23:0]                f;

  // a 50-cycle minute keeps the timers short
  dsfct_serial #(.MINUTE_CYCLES(32'h00000032)) dut_u (.clk, .reset_n, .serial_clk,
    .chip_select_n, .serial_in_line, .serial_out_line, .balance_request, .balance_output,
    .sleep_request, .convert_start, .conv_valid, .conv_ready, .conv_word, .up_frame,
    .up_valid, .chain_rd_frame, .chain_rd_valid, .down_frame, .down_valid);

  dsfct_host_model host_u (.serial_clk, .chip_select_n, .serial_in_line, .serial_out_line);

  // system clock
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // collect forwarded writes
  always @(negedge clk)
    if (up_valid === 1'h1)
      upq.push_back(up_frame);

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [1:0] crc2(input logic [15:0] d);
    logic x;
    logic s1;
    logic s2;
    x = 1'h0;
    s1 = 1'h0;
    s2 = 1'h0;
    for (int i = 15; i >= 0; i--)
    begin
      s2 = s1;
      s1 = x;
      x = d[i] ^ s2;
    end
    return {s1, x};
  endfunction

  function automatic logic [23:0] wf(input logic [5:0] dv, input logic [5:0] ra,
                                     input logic [7:0] d, input logic all);
    return {dv[0], dv[1], dv[2], dv[3], dv[4], dv[5], ra, d, all, 3'h0};
  endfunction

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [5:0] ra, input logic [7:0] d);
    host_u.xfer(wf(6'h00, ra, d, 1'h0), 1'h0, rx);
    if (ra >= 6'h15 && ra <= 6'h1A)
      regs[ra] = d[7:3] > 5'h1E ? 8'hF0 : d & 8'hF8;
    else if (ra == 6'h1B)
      regs[ra] = d & 8'hF8;
    else if (ra == 6'h1C)
      regs[ra] = d & 8'hFC;
  endtask

  task automatic rd(input logic [5:0] ra);
    logic [15:0] p;
    wr(6'h1C, {ra, 2'h0});
    host_u.xfer(24'h000000, 1'h0, rx);
    p = {ra, regs[ra], 2'h0};
    check("register frame", rx, {6'h00, p, crc2(p)});
  endtask

  // the buffer only takes a word at an edge where ready was high
  task automatic push(input logic [15:0] w);
    conv_valid = 1'h1;
    conv_word = w;
    while (conv_ready !== 1'h1)
      @(negedge clk);
    @(negedge clk);
    convq.push_back(w);
  endtask

  task automatic rdconv(input bit hold, input logic [5:0] dv);
    logic [15:0] p;
    host_u.xfer(wf(dv, 6'h15, 8'hFF, 1'h0), hold, rx);
    p = convq.size() ? convq.pop_front() : 16'h0000;
    check("conversion frame", rx, {6'h00, p, crc2(p)});
    check("forward count", 24'(upq.size()), 24'h000001);
    check("forwarded frame", upq.pop_front(), wf(dv - 6'h01, 6'h15, 8'hFF, 1'h0));
  endtask

  // watchdog, well past the expected run
  initial
  begin
    #2_000_000;
    fail_count++;
    summarize();
  end

  initial
  begin
    reset_n = 1'h0;
    balance_request = 6'h00;
    conv_valid = 1'h0;
    conv_word = 16'h0000;
    chain_rd_frame = 24'h000000;
    chain_rd_valid = 1'h0;
    fail_count = 0;
    total_checks = 0;
    rng = 32'h00000A3C;
    foreach (regs[i])
      regs[i] = 8'h00;
    repeat (4) @(negedge clk);
    reset_n = 1'h1;
    repeat (4) @(negedge clk);
    check("crc example one", 24'(crc2(16'h5A79)), 24'h000001);
    check("crc example two", 24'(crc2(16'h3F28)), 24'h000003);
    // fill the buffer until it refuses
    repeat (8) push(16'(rnd()));
    conv_word = 16'(rnd());
    check("buffer full", 24'(conv_ready), 24'h000000);
    repeat (4) @(negedge clk);
    conv_valid = 1'h0;
    for (int k = 0; k < 8; k++)
      rdconv(k != 7, 6'(k + 1));
    @(negedge clk);
    repeat (2) push(16'(rnd()));
    conv_valid = 1'h0;
    repeat (3) rdconv(1'h0, 6'h3A);
    for (int r = 8'h15; r <= 8'h1C; r++)
      rd(6'(r));
    for (int r = 8'h15; r <= 8'h1C; r++)
    begin
      wr(6'(r), r == 8'h15 ? 8'hF8 : 8'(rnd()) & (r == 8'h1C ? 8'hFC : 8'hF8));
      rd(6'(r));
    end
    host_u.xfer(wf(6'h05, 6'h16, 8'h50, 1'h1), 1'h0, rx);
    regs[8'h16] = 8'h50;
    check("all parts forward", upq.pop_front(), wf(6'h05, 6'h16, 8'h50, 1'h1));
    rd(6'h16);
    wr(6'h15, 8'h10);
    wr(6'h16, 8'h00);
    @(negedge clk);
    balance_request = 6'h03;
    repeat (3) @(negedge clk);
    check("balance on", 24'(balance_output), 24'h000003);
    repeat (110) @(negedge clk);
    check("balance timed", 24'(balance_output), 24'h000002);
    balance_request = 6'h00;
    wr(6'h1B, 8'h00);
    repeat (120) @(negedge clk);
    check("sleep disabled", 24'(sleep_request), 24'h000000);
    wr(6'h1B, 8'h18);
    repeat (160) @(negedge clk);
    check("sleep after minute", 24'(sleep_request), 24'h000001);
    repeat (4)
    begin
      f = 24'(rnd());
      chain_rd_frame = f;
      chain_rd_valid = 1'h1;
      @(negedge clk);
      chain_rd_valid = 1'h0;
      check("relay valid", 24'(down_valid), 24'h000001);
      check("relay frame", down_frame, {f[23:18] + 6'h01, f[17:0]});
      @(negedge clk);
    end
    summarize();
  end
endmodule // dsfct_serial_bench
